// ===== dv/iasc_bus_peer.sv
// Bus peer that frames one address byte toward the block
`timescale 1ns/1ps
`default_nettype none
module iasc_bus_peer (
    input wire logic clk_i,
    output logic start_o,
    output logic bit_valid_o,
    output logic bit_o,
    output logic ack_o
);
    initial {start_o, bit_valid_o, bit_o, ack_o} = 4'h0;
    // Gap gives a slow peer; released data line shows the inverse bit
    task send(input logic [7:0] b, input integer gap);
        integer k;
        start_o = 1;
        @(posedge clk_i) #1 start_o = 0;
        for (k = 7; k >= 0; k--) begin
            bit_o = b[k];
            bit_valid_o = 1;
            @(posedge clk_i) #1;
            if (gap > 0) begin
                {bit_valid_o, bit_o} = {1'b0, ~b[k]};
                repeat (gap) @(posedge clk_i) #1;
            end
        end
        {bit_valid_o, ack_o} = 2'h1;
        @(posedge clk_i) #1 ack_o = 0;
    endtask
endmodule // iasc_bus_peer
`default_nettype wire

// ===== dv/iasc_top_sva.sv
// Checker for address match and state code behaviour
`timescale 1ns/1ps
`default_nettype none
module iasc_top_chk (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic master_mode_i,
    input wire logic ack_i,
    input wire logic ext_event_i,
    input wire logic [4:0] ext_code_i,
    input wire logic event_flag_clr_i,
    input wire logic event_flag_o,
    input wire logic addr_match_o,
    input wire logic [7:0] state_code_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence addr_ack;
        ce_i && addr_match_o && ack_i;
    endsequence
    sequence other_ev;
        ce_i && ext_event_i && !(addr_match_o && ack_i);
    endsequence
    low_zero_a: assert property (event_flag_o |-> !state_code_o[2:0])
        else $error("code low bits set");
    master_off_a: assert property (master_mode_i |-> !addr_match_o)
        else $error("match in master mode");
    ack_code_a: assert property (addr_ack |=> event_flag_o &&
        state_code_o inside {8'h60, 8'h70, 8'hA8}) else $error("ack code");
    ext_code_a: assert property (other_ev |=> event_flag_o &&
        state_code_o == {$past(ext_code_i), 3'h0}) else $error("event code");
    flag_hold_a: assert property (event_flag_o && !event_flag_clr_i
        |=> event_flag_o) else $error("flag lost");
    flag_clear_a: assert property (ce_i && event_flag_clr_i && !ack_i &&
        !ext_event_i |=> !event_flag_o) else $error("flag stuck");
    sta_write_a: assert property (ce_i && sfr_wr_i && sfr_addr_i == 8'hC1 &&
        !ack_i && !ext_event_i |=> $stable(state_code_o)) else $error("code written");
    sta_read_a: assert property (ce_i && sfr_addr_i == 8'hC1
        |=> sfr_rdata_o == $past(state_code_o)) else $error("code read");
    freeze_a: assert property (!ce_i |=> $stable(state_code_o) &&
        $stable(event_flag_o)) else $error("state moved while frozen");
endmodule // iasc_top_chk
bind iasc_top iasc_top_chk chk (.core_clk_i, .rst_n_i, .ce_i, .sfr_addr_i,
    .sfr_wr_i, .sfr_rdata_o, .master_mode_i, .ack_i, .ext_event_i, .ext_code_i,
    .event_flag_clr_i, .event_flag_o, .addr_match_o, .state_code_o);
`default_nettype wire

// ===== dv/iasc_top_tb_top.sv
// Self-checking bench for the address match and state code block
`timescale 1ns/1ps
`default_nettype none
module iasc_top_tb_top;
    logic core_clk_i = 0, rst_n_i = 0, ce_i = 1, sfr_wr_i = 0;
    logic master_mode_i = 0, ext_event_i = 0, event_flag_clr_i = 0;
    logic [7:0] sfr_addr_i = 0, sfr_wdata_i = 0, sfr_rdata_o, state_code_o;
    logic [4:0] ext_code_i = 0;
    logic start_i, bit_valid_i, bit_i, ack_i, event_flag_o, addr_match_o;
    integer n_mismatch = 0, compares = 0, seed = 5, cyc = 0, own, i, b, e;
    always #4 core_clk_i = ~core_clk_i;
    iasc_bus_peer peer (.clk_i(core_clk_i), .start_o(start_i),
        .bit_valid_o(bit_valid_i), .bit_o(bit_i), .ack_o(ack_i));
    iasc_top dut (.core_clk_i, .rst_n_i, .ce_i, .sfr_addr_i, .sfr_wr_i,
        .sfr_wdata_i, .sfr_rdata_o, .master_mode_i, .start_i, .bit_valid_i,
        .bit_i, .ack_i, .ext_event_i, .ext_code_i, .event_flag_clr_i,
        .event_flag_o, .addr_match_o, .state_code_o);
    task give_verdict;
        if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task tick; @(posedge core_clk_i) #1; endtask
    task chk(input logic [7:0] got, input integer x);
        compares++;
        if (got !== x[7:0]) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, got, x[7:0]);
        end
    endtask
    task rd(input logic [7:0] a, input integer x);
        sfr_addr_i = a;
        tick;
        chk(sfr_rdata_o, x);
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        {sfr_addr_i, sfr_wdata_i, sfr_wr_i} = {a, d, 1'b1};
        tick;
        sfr_wr_i = 0;
    endtask
    always @(posedge core_clk_i) if (++cyc == 5000) begin
        n_mismatch++;
        give_verdict;
    end
    initial begin
        repeat (2) tick;
        rst_n_i = 1;
        rd(8'hC1, 0);
        for (i = 0; i < 60; i++) begin
            own = $random(seed) & 255;
            b = (i % 3) ? {own[7:1], i[1]} : ($random(seed) & 255);
            if (i % 5 == 0) b = i[2];
            master_mode_i = (i % 7 == 3);
            wr(8'hC3, own[7:0]);
            rd(8'hC3, own);
            peer.send(b[7:0], i % 2);
            e = -1;
            if (!master_mode_i && b[7:1] == own[7:1]) e = b[0] ? 'hA8 : 'h60;
            else if (!master_mode_i && b == 0 && own[0]) e = 'h70;
            chk({7'h0, event_flag_o}, e >= 0);
            if (e >= 0) chk(state_code_o, e);
            if (e >= 0) rd(8'hC1, e);
            event_flag_clr_i = 1;
            tick;
            event_flag_clr_i = 0;
            chk({7'h0, event_flag_o}, 0);
        end
        {ext_code_i, ext_event_i} = {5'h1B, 1'b1};
        tick;
        ext_event_i = 0;
        chk(state_code_o, 'hD8);
        wr(8'hC1, 8'hFF);
        rd(8'hC1, 'hD8);
        rd(8'h55, 0);
        {ce_i, ext_code_i, ext_event_i} = {1'b0, 5'h05, 1'b1};
        tick;
        {ce_i, ext_event_i} = 2'h2;
        chk(state_code_o, 'hD8);
        give_verdict;
    end
endmodule // iasc_top_tb_top
`default_nettype wire

// ===== src/iasc_consts.vh
// Constants for the slave address match and state code block
`ifndef IASC_CONSTS_VH
`define IASC_CONSTS_VH
`define IASC_ADR_OFFSET 8'hC3
`define IASC_STA_OFFSET 8'hC1
`define IASC_ADR_RESET 8'h00
`define IASC_STA_RESET 8'h00
`define IASC_GC_BIT 0
`define IASC_ADDR_MSB 7
`define IASC_ADDR_LSB 1
`define IASC_GC_ADDR 7'h00
`define IASC_ST_OWN_W 8'h60
`define IASC_ST_GC 8'h70
`define IASC_ST_OWN_R 8'hA8
`define IASC_ZERO_BITS 3'h0
`endif

// ===== src/iasc_match.v
// Serial address comparator, most significant bit first
`timescale 1ns/1ps
`default_nettype none
module iasc_match (
    input wire core_clk_i,
    input wire rst_n_i,
    input wire ce_i,
    input wire start_i,
    input wire bit_valid_i,
    input wire bit_i,
    input wire [6:0] own_addr_i,
    output reg own_hit_o,
    output reg gc_hit_o,
    output reg [2:0] bit_cnt_o
);
    // ==========================================================
    // Bitwise compare
    wire [2:0] idx;
    assign idx = 3'h6 - bit_cnt_o;
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            own_hit_o <= 1'b0;
            gc_hit_o <= 1'b0;
            bit_cnt_o <= 3'h0;
        end else if (ce_i) begin
            if (start_i) begin
                own_hit_o <= 1'b1;
                gc_hit_o <= 1'b1;
                bit_cnt_o <= 3'h0;
            end else if (bit_valid_i && bit_cnt_o != 3'h7) begin
                // First received bit meets stored bit 6
                if (bit_i != own_addr_i[idx])
                    own_hit_o <= 1'b0;
                if (bit_i)
                    gc_hit_o <= 1'b0;
                bit_cnt_o <= bit_cnt_o + 3'h1;
            end
        end
    end
endmodule // iasc_match
`default_nettype wire

// ===== src/iasc_top.v
// Own address register, address recognition and state code register
//
// Function
// - Own slave address comes from address register bits seven down to one.
// - General call address zero is recognised only when bit zero is set.
// - In master mode the address register is ignored for address recognition; it can still be written and read.
// - Stored address bits compared MSB first against received bits.
// - Matching own address answered for both write and read direction.
// - Twenty-eight bus states each get a distinct eight-bit code.
// - Code sits in bits seven to three; low three bits read zero.
// - Code is valid only while the serial event flag is set.
// - State code register is eight bits, resets to zero, at 0xC1.
// - Own address with write, acknowledged, reports 0x60 and raises flag.
// - General call acknowledged reports 0x70 and raises flag.
// - Own address with read, acknowledged, reports 0xA8 and raises flag.
`timescale 1ns/1ps
`default_nettype none
`include "iasc_consts.vh"
module iasc_top (
    input wire core_clk_i,
    input wire rst_n_i,
    input wire ce_i,
    input wire [7:0] sfr_addr_i,
    input wire sfr_wr_i,
    input wire [7:0] sfr_wdata_i,
    output reg [7:0] sfr_rdata_o,
    input wire master_mode_i,
    input wire start_i,
    input wire bit_valid_i,
    input wire bit_i,
    input wire ack_i,
    input wire ext_event_i,
    input wire [4:0] ext_code_i,
    input wire event_flag_clr_i,
    output reg event_flag_o,
    output wire addr_match_o,
    output reg [7:0] state_code_o
);
    // ==========================================================
    // Registers
    reg [7:0] own_slave_address;
    reg [7:0] bus_state_code;
    reg rw_bit;
    reg addr_done;
    wire own_hit;
    wire gc_hit;
    wire [2:0] bit_cnt;
    wire [6:0] own_addr_bits;
    wire gencall_enable;
    wire slave_ok;
    wire own_ok;
    wire gc_ok;
    wire addr_ack;
    reg [7:0] next_code;
    reg next_set;
    assign own_addr_bits = own_slave_address[`IASC_ADDR_MSB:`IASC_ADDR_LSB];
    assign gencall_enable = own_slave_address[`IASC_GC_BIT];
    assign slave_ok = !master_mode_i;
    assign own_ok = slave_ok && own_hit;
    assign gc_ok = slave_ok && gencall_enable && gc_hit && !rw_bit;
    assign addr_match_o = addr_done && (own_ok || gc_ok);
    assign addr_ack = addr_done && ack_i;
    // ==========================================================
    // Address comparator
    iasc_match u_match (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .start_i(start_i),
        .bit_valid_i(bit_valid_i),
        .bit_i(bit_i),
        .own_addr_i(own_addr_bits),
        .own_hit_o(own_hit),
        .gc_hit_o(gc_hit),
        .bit_cnt_o(bit_cnt)
    );
    // ==========================================================
    // Direction bit capture, eighth bit of the address byte
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rw_bit <= 1'b0;
            addr_done <= 1'b0;
        end else if (ce_i) begin
            if (start_i) begin
                addr_done <= 1'b0;
            end else if (bit_valid_i && bit_cnt == 3'h7 && !addr_done) begin
                rw_bit <= bit_i;
                addr_done <= 1'b1;
            end else if (addr_ack) begin
                addr_done <= 1'b0;
            end
        end
    end
    // ==========================================================
    // Next state code
    always @* begin
        next_code = bus_state_code;
        next_set = 1'b0;
        if (addr_ack && own_ok) begin
            // Own address wins over general call when both match
            next_set = 1'b1;
            if (rw_bit)
                next_code = `IASC_ST_OWN_R;
            else
                next_code = `IASC_ST_OWN_W;
        end else if (addr_ack && gc_ok) begin
            next_set = 1'b1;
            next_code = `IASC_ST_GC;
        end else if (ext_event_i) begin
            // Other states come from the sequencer as a five-bit field
            next_set = 1'b1;
            next_code = {ext_code_i, `IASC_ZERO_BITS};
        end
    end
    // ==========================================================
    // Register file
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            own_slave_address <= `IASC_ADR_RESET;
            bus_state_code <= `IASC_STA_RESET;
            event_flag_o <= 1'b0;
            state_code_o <= `IASC_STA_RESET;
        end else if (ce_i) begin
            if (sfr_wr_i && sfr_addr_i == `IASC_ADR_OFFSET)
                own_slave_address <= sfr_wdata_i;
            // Writes to the code register are dropped, never stored
            if (next_set) begin
                bus_state_code <= next_code;
                state_code_o <= next_code;
            end
            // Set beats a clear arriving in the same cycle
            if (next_set)
                event_flag_o <= 1'b1;
            else if (event_flag_clr_i)
                event_flag_o <= 1'b0;
        end
    end
    // ==========================================================
    // Read mux, unmapped addresses read zero
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            sfr_rdata_o <= 8'h00;
        end else if (ce_i) begin
            case (sfr_addr_i)
                `IASC_ADR_OFFSET: sfr_rdata_o <= own_slave_address;
                `IASC_STA_OFFSET: sfr_rdata_o <= bus_state_code;
                default: sfr_rdata_o <= 8'h00;
            endcase
        end
    end
endmodule // iasc_top
`default_nettype wire
